// ===== design/prc_reply_channel.sv
`timescale 1ns/1ps

// Summary of operation
// - device drives its own dedicated 5-bit reply bus to the controller.
// - reply packet lasts one or two cycles; first holds type and class.
// - second cycle carries master id of the original requester.
// - idle is 0000 class 0 one cycle; fatal error is 0100 one cycle.
// - two-cycle codes 0101,0111,1000,1010,1100,1101 copy request class bit.
// - only fatal error is unsolicited; other replies answer a controller request.
// - fatal error may go out at any cycle, meaning coherency lost.
// - fatal error is sent on address bus or cache tag parity error.
// - idle type driven after reset and whenever no reply is active.
// - noncached block read gets read error, no data; cacheable read undefined.
// - single read ack means 16 bytes ready; next noncached request may follow.
// - interrupt ack means interrupt serviced; next interrupt may then be sent.
// - snoop ack for cached line not awaiting writeback; copyback gives 64 bytes.
// - dirty-victim ack for victimized line awaiting writeback; copyback gives 64 bytes.
// - snoop miss only with no-directory flag set and line absent.
// - interrupt ack waits until software clears busy after unacked interrupt.
// - dirty-victim ack repeats until pending read and writeback both complete.
module prc_reply_channel
	import prc_pkg::*;
(
	input  wire logic                       clk_i,             // interconnect clock
	input  wire logic                       rst_n_i,           // sync reset, active low
	input  wire prc_pkg::prc_req_s          req_i,             // request fields
	input  wire logic                       req_valid_i,       // one-cycle request strobe
	input  wire prc_pkg::prc_snoop_s        snoop_i,           // line state for snoops
	input  wire logic                       victim_busy_i,     // read or writeback pending
	input  wire logic                       single_ready_i,    // 16 bytes read data ready
	input  wire logic                       intr_busy_i,       // software busy bit level
	input  wire logic                       addr_parity_err_i, // async pin, parity fault
	input  wire logic                       tag_parity_err_i,  // async pin, tag fault
	output logic [prc_pkg::REPLY_W-1:0]     reply_o,           // reply bus to controller
	output logic                            req_ready_o,       // may take a new request
	output logic                            fatal_o            // fatal error latched
);
	import prc_pkg::*;

	// parity error pins come from outside, two-flop synchronised
	logic [1:0] par_meta_ff, nxt_par_meta;
	logic [1:0] par_sync_ff, nxt_par_sync;

	always_comb begin
		nxt_par_meta = rst_n_i ? {tag_parity_err_i, addr_parity_err_i} : 2'h0;
		nxt_par_sync = rst_n_i ? par_meta_ff : 2'h0;
	end

	always_ff @(posedge clk_i) begin
		par_meta_ff <= nxt_par_meta;
		par_sync_ff <= nxt_par_sync;
	end

	// pending request and reply state
	prc_state_e        state_ff, nxt_state;
	prc_type_e         type_ff, nxt_type;
	logic              class_ff, nxt_class;
	logic [MID_W-1:0]  mid_ff, nxt_mid;
	logic              wait_single_ff, nxt_wait_single;
	logic              wait_intr_ff, nxt_wait_intr;
	logic              fatal_ff, nxt_fatal;
	logic              fatal_sent_ff, nxt_fatal_sent;
	logic [REPLY_W-1:0] reply_ff, nxt_reply;
	logic              two_cycle;
	prc_type_e         snoop_type;
	logic              snoop_valid;

	// snoop answer selection: dirty victim beats hit, miss needs the flag
	always_comb begin
		snoop_valid = 1'b1;
		if (snoop_i.victim_pending || victim_busy_i) begin
			snoop_type = RTYPE_DIRTY_ACK;
		end else if (snoop_i.hit) begin
			snoop_type = RTYPE_SNOOP_ACK;
		end else if (req_i.no_directory_flag) begin
			snoop_type = RTYPE_SNOOP_MISS;
		end else begin
			// miss without the flag has no legal answer; stay silent
			snoop_type  = RTYPE_IDLE;
			snoop_valid = 1'b0;
		end
	end

	assign req_ready_o = (state_ff == ST_IDLE) && !wait_single_ff && !wait_intr_ff;
	assign two_cycle   = 1'b1;
	assign fatal_o     = fatal_ff;
	assign reply_o     = reply_ff;

	// framer next state
	always_comb begin
		nxt_state       = state_ff;
		nxt_type        = type_ff;
		nxt_class       = class_ff;
		nxt_mid         = mid_ff;
		nxt_wait_single = wait_single_ff;
		nxt_wait_intr   = wait_intr_ff;
		nxt_fatal       = fatal_ff | (|par_sync_ff);
		nxt_fatal_sent  = fatal_sent_ff;
		nxt_reply       = REPLY_IDLE_WORD;

		// take a request only when no reply is pending
		if (req_valid_i && req_ready_o) begin
			nxt_class = req_i.class_bit;
			nxt_mid   = req_i.mid;
			case (req_i.kind)
				REQ_NC_BLOCK_READ: begin
					nxt_type  = RTYPE_READ_ERROR;
					nxt_state = ST_FIRST;
				end
				REQ_NC_SINGLE_READ: begin
					nxt_wait_single = 1'b1;
				end
				REQ_INTERRUPT: begin
					nxt_wait_intr = 1'b1;
				end
				REQ_INVALIDATE, REQ_COPY_INVAL, REQ_COPYBACK, REQ_COPYBACK_SHR: begin
					if (snoop_valid) begin
						nxt_type  = snoop_type;
						nxt_state = ST_FIRST;
					end
				end
				default: begin
					// cacheable read is undefined; it is dropped
					nxt_state = ST_IDLE;
				end
			endcase
		end

		// deferred acks launch once their condition holds
		if (state_ff == ST_IDLE && wait_single_ff && single_ready_i) begin
			nxt_type        = RTYPE_SINGLE_ACK;
			nxt_state       = ST_FIRST;
			nxt_wait_single = 1'b0;
		end else if (state_ff == ST_IDLE && wait_intr_ff && !intr_busy_i) begin
			nxt_type      = RTYPE_INTR_ACK;
			nxt_state     = ST_FIRST;
			nxt_wait_intr = 1'b0;
		end

		case (state_ff)
			ST_FIRST: begin
				nxt_reply = {type_ff, class_ff};
				nxt_state = two_cycle ? ST_SECOND : ST_IDLE;
			end
			ST_SECOND: begin
				nxt_reply = mid_ff;
				nxt_state = ST_IDLE;
			end
			ST_IDLE: begin
				nxt_reply = REPLY_IDLE_WORD;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase

		// fatal error pre-empts everything, one cycle, then idle forever
		// since only a system reset can recover coherency
		if (fatal_ff) begin
			nxt_state = ST_IDLE;
			nxt_reply = fatal_sent_ff ? REPLY_IDLE_WORD
			                          : {RTYPE_FATAL_ERROR, 1'b0};
			nxt_fatal_sent = 1'b1;
		end

		if (!rst_n_i) begin
			nxt_state       = ST_IDLE;
			nxt_type        = RTYPE_IDLE;
			nxt_class       = 1'b0;
			nxt_mid         = '0;
			nxt_wait_single = 1'b0;
			nxt_wait_intr   = 1'b0;
			nxt_fatal       = 1'b0;
			nxt_fatal_sent  = 1'b0;
			nxt_reply       = REPLY_IDLE_WORD;
		end
	end

	// only enum codes reach the bus, so no undefined type can leave
	always_ff @(posedge clk_i) begin
		state_ff       <= nxt_state;
		type_ff        <= nxt_type;
		class_ff       <= nxt_class;
		mid_ff         <= nxt_mid;
		wait_single_ff <= nxt_wait_single;
		wait_intr_ff   <= nxt_wait_intr;
		fatal_ff       <= nxt_fatal;
		fatal_sent_ff  <= nxt_fatal_sent;
		reply_ff       <= nxt_reply;
	end

endmodule

// ===== design/prc_pkg.sv
package prc_pkg;

	// reply bus width and field layout
	localparam int REPLY_W   = 5;
	localparam int TYPE_W    = 4;
	localparam int MID_W     = 5;
	localparam int CLASS_BIT = 0;
	localparam int TYPE_LSB  = 1;

	// reply type codes
	typedef enum logic [3:0] {
		RTYPE_IDLE        = 4'h0,
		RTYPE_FATAL_ERROR = 4'h4,
		RTYPE_READ_ERROR  = 4'h5,
		RTYPE_SNOOP_MISS  = 4'h7,
		RTYPE_SINGLE_ACK  = 4'h8,
		RTYPE_SNOOP_ACK   = 4'hA,
		RTYPE_INTR_ACK    = 4'hC,
		RTYPE_DIRTY_ACK   = 4'hD
	} prc_type_e;

	// incoming request kinds from the system controller
	typedef enum logic [2:0] {
		REQ_NC_BLOCK_READ  = 3'h0,
		REQ_NC_SINGLE_READ = 3'h1,
		REQ_INTERRUPT      = 3'h2,
		REQ_INVALIDATE     = 3'h3,
		REQ_COPY_INVAL     = 3'h4,
		REQ_COPYBACK       = 3'h5,
		REQ_COPYBACK_SHR   = 3'h6,
		REQ_CACHEABLE_READ = 3'h7
	} prc_req_e;

	// one request as seen by the reply channel
	typedef struct packed {
		prc_req_e         kind;
		logic             class_bit;
		logic [MID_W-1:0] mid;
		logic             no_directory_flag;
	} prc_req_s;

	// snoop lookup result for the requested line
	typedef struct packed {
		logic hit;
		logic victim_pending;
	} prc_snoop_s;

	// packet framer states, gray coded along idle -> first -> second
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_FIRST  = 2'b01,
		ST_SECOND = 2'b11
	} prc_state_e;

	localparam logic [REPLY_W-1:0] REPLY_IDLE_WORD = 5'h00;

endpackage

// ===== bench/prc_ctrl_model.sv
`timescale 1ns/1ps
// controller side: splits the reply bus into whole packets
module prc_ctrl_model (
	input	wire logic	clk_i,	// clock
	input	wire logic	rst_n_i,	// reset
	input	wire logic [4:0]	reply_i,	// reply bus
	output	logic [9:0]	pkt_o,	// type, class, id
	output	logic	stb_o,	// packet done
	output	logic	sys_rst_n_o	// system reset
);
	logic	two_ff;
	// fatal is one word; every other nonzero type has a second word
	always_ff @(posedge clk_i) begin
		stb_o <= 1'b0;
		if (!rst_n_i) begin
			two_ff <= 1'b0;
			sys_rst_n_o <= 1'b1;
		end else if (two_ff) begin
			two_ff <= 1'b0;
			pkt_o[4:0] <= reply_i;
			stb_o <= 1'b1;
		end else if (reply_i[4:1] == 4'h4) begin
			pkt_o <= {reply_i, 5'h00};
			stb_o <= 1'b1;
			sys_rst_n_o <= 1'b0;
		end else if (reply_i != 5'h00) begin
			pkt_o[9:5] <= reply_i;
			two_ff <= 1'b1;
		end
	end
endmodule

// ===== bench/prc_reply_properties.sv
`timescale 1ns/1ps
module prc_reply_properties
	import prc_pkg::*;
(
	input	wire logic	clk_i,	// clock
	input	wire logic	rst_n_i,	// reset
	input	wire prc_pkg::prc_req_s	req_i,	// request
	input	wire logic	req_valid_i,	// strobe
	input	wire prc_pkg::prc_snoop_s	snoop_i,	// line state
	input	wire logic	victim_busy_i,	// pending
	input	wire logic [prc_pkg::REPLY_W-1:0]	reply_o,	// reply bus
	input	wire logic	req_ready_o,	// ready
	input	wire logic	fatal_o	// fatal
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic	tk, snp, cln;
	// taken request, snoop kinds, line free of writeback
	assign tk = req_valid_i && req_ready_o;
	assign snp = req_i.kind inside {REQ_INVALIDATE, REQ_COPY_INVAL, REQ_COPYBACK, REQ_COPYBACK_SHR};
	assign cln = !snoop_i.victim_pending && !victim_busy_i;
	// read error word pair, then idle
	sequence s_rerr;
		reply_o == {RTYPE_READ_ERROR, $past(req_i.class_bit, 2)} ##1
		reply_o == $past(req_i.mid, 3) ##1 reply_o == 5'h00;
	endsequence
	a_rerr_pkt: assert property (tk && req_i.kind == REQ_NC_BLOCK_READ |=> !req_ready_o ##1 s_rerr)
		else $error("read error packet wrong");
	a_fatal_word: assert property ($rose(fatal_o) |=> reply_o == {RTYPE_FATAL_ERROR, 1'b0} ##1 reply_o == 5'h00)
		else $error("fatal word wrong");
	a_fatal_hold: assert property (fatal_o |=> fatal_o)
		else $error("fatal dropped");
	a_fatal_quiet: assert property ($past(fatal_o, 2) |-> reply_o == 5'h00)
		else $error("reply after fatal");
	a_no_unasked: assert property (req_ready_o && $past(req_ready_o) && !$past(fatal_o) |-> reply_o == 5'h00)
		else $error("unsolicited reply");
	a_dirty_ack: assert property (tk && snp && !cln |-> ##2 reply_o[4:1] == RTYPE_DIRTY_ACK)
		else $error("dirty ack missing");
	a_snoop_hit: assert property (tk && snp && cln && snoop_i.hit |-> ##2 reply_o[4:1] == RTYPE_SNOOP_ACK)
		else $error("snoop ack missing");
	a_miss_quiet: assert property (tk && snp && cln && !snoop_i.hit && !req_i.no_directory_flag |-> ##2 reply_o == 5'h00 [*2])
		else $error("miss reply without flag");
endmodule
bind prc_reply_channel prc_reply_properties u_props (.clk_i, .rst_n_i, .req_i, .req_valid_i, .snoop_i,
	.victim_busy_i, .reply_o, .req_ready_o, .fatal_o);

// ===== bench/prc_tb.sv
`timescale 1ns/1ps
module tb;
	import prc_pkg::*;
	logic	clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, victim_busy_i = 1'b0;
	logic	single_ready_i = 1'b0, intr_busy_i = 1'b0, addr_parity_err_i = 1'b0;
	logic	tag_parity_err_i = 1'b0, req_ready_o, fatal_o, stb, sys_rst_n;
	prc_req_s	req_i = '0;
	prc_snoop_s	snoop_i = '0;
	logic [4:0]	reply_o;
	logic [9:0]	pkt;
	int	error_cnt = 0, checks_done = 0, cyc = 0;
	always #2 clk_i = ~clk_i;
	prc_reply_channel uut (.clk_i, .rst_n_i, .req_i, .req_valid_i, .snoop_i, .victim_busy_i,
		.single_ready_i, .intr_busy_i, .addr_parity_err_i, .tag_parity_err_i, .reply_o,
		.req_ready_o, .fatal_o);
	prc_ctrl_model ctrl (.clk_i, .rst_n_i, .reply_i(reply_o), .pkt_o(pkt), .stb_o(stb),
		.sys_rst_n_o(sys_rst_n));
	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle strobe, taken only while ready
	task automatic send(input prc_req_e k, input logic c, input logic [4:0] m, input logic f);
		@(posedge clk_i);
		#1;
		chk({9'h0, req_ready_o}, 10'h001);
		req_i = '{k, c, m, f};
		req_valid_i = 1'b1;
		@(posedge clk_i);
		#1;
		req_valid_i = 1'b0;
	endtask
	// fixed watch window; zero means no packet may arrive in it
	task automatic expect_pkt(input logic [9:0] exp);
		logic got;
		got = 1'b0;
		repeat (12) begin
			@(posedge clk_i);
			#1;
			if (stb && !got) begin
				chk(pkt, exp);
				got = 1'b1;
			end
		end
		chk({9'h0, got}, {9'h0, exp != 10'h0});
	endtask
	task automatic t_ncread();
		send(REQ_NC_BLOCK_READ, 1'b1, 5'h13, 1'b0);
		expect_pkt({RTYPE_READ_ERROR, 6'h33});
	endtask
	task automatic snp_case(input prc_req_e k, input logic [2:0] st, input logic f, input logic [9:0] e);
		{snoop_i, victim_busy_i} = st;
		send(k, 1'b0, 5'h0A, f);
		expect_pkt(e);
	endtask
	task automatic t_snoop();
		snp_case(REQ_INVALIDATE, 3'b010, 1'b0, {RTYPE_DIRTY_ACK, 6'h0A});
		snp_case(REQ_COPY_INVAL, 3'b101, 1'b1, {RTYPE_DIRTY_ACK, 6'h0A});
		snp_case(REQ_COPYBACK, 3'b100, 1'b0, {RTYPE_SNOOP_ACK, 6'h0A});
		snp_case(REQ_COPYBACK_SHR, 3'b000, 1'b1, {RTYPE_SNOOP_MISS, 6'h0A});
		snp_case(REQ_COPYBACK, 3'b000, 1'b0, 10'h000);
		{snoop_i, victim_busy_i} = 3'b000;
	endtask
	task automatic t_single();
		send(REQ_NC_SINGLE_READ, 1'b1, 5'h1F, 1'b0);
		expect_pkt(10'h000);
		single_ready_i = 1'b1;
		expect_pkt({RTYPE_SINGLE_ACK, 6'h3F});
		single_ready_i = 1'b0;
	endtask
	task automatic t_intr();
		intr_busy_i = 1'b1;
		send(REQ_INTERRUPT, 1'b1, 5'h02, 1'b0);
		expect_pkt(10'h000);
		intr_busy_i = 1'b0;
		expect_pkt({RTYPE_INTR_ACK, 6'h22});
	endtask
	task automatic t_fatal();
		tag_parity_err_i = 1'b1;
		expect_pkt({RTYPE_FATAL_ERROR, 6'h00});
		chk({9'h0, sys_rst_n}, 10'h000);
		chk({9'h0, fatal_o}, 10'h001);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		chk({5'h00, reply_o}, 10'h000);
		t_ncread();
		t_snoop();
		t_single();
		t_intr();
		t_fatal();
		print_verdict();
	end
endmodule
